// ==== inc/acs_pkg.sv ====
package acs_pkg;

  // ----------------------------------------
  // Register port geometry
  // ----------------------------------------
  localparam int ACS_ADDR_W = 13;
  localparam int ACS_DATA_W = 8;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [12:0] CHAN_SEL_ADDR = 13'h005;
  localparam logic [12:0] COMMIT_ADDR = 13'h0FF;
  localparam logic [12:0] SHADOW_FIRST = 13'h008;
  localparam logic [12:0] SHADOW_LAST = 13'h018;
  localparam int SHADOW_DEPTH = 17;
  localparam int SHADOW_IDX_W = 5;

  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int CHAN_A_BIT = 0;
  localparam int CHAN_B_BIT = 1;
  localparam logic [1:0] CHAN_SEL_RESET = 2'h3;
  localparam int COMMIT_BIT = 0;
  // Stabilizer enable, global, entry of 0x09
  localparam int DCS_IDX = 1;
  localparam int DCS_BIT = 0;
  // Twos complement select, local, entry of 0x14
  localparam int FMT_IDX = 12;
  localparam int FMT_BIT = 0;
  // One bit per shadow entry: set means duplicated per channel
  localparam logic [16:0] LOCAL_MASK = 17'h01000;
  localparam logic [135:0] SHADOW_RESET = 136'h0100;

  // Strap and output defaults
  localparam logic DCS_DEFAULT = 1'b1;
  localparam logic FMT_DEFAULT = 1'b0;
  localparam logic HIZ_DEFAULT = 1'b0;
  localparam logic POWER_DOWN_PIN_DEFAULT = 1'b0;

  // Read source of the last accepted read
  localparam logic [1:0] RD_ZERO = 2'h0;
  localparam logic [1:0] RD_CHAN_SEL = 2'h1;
  localparam logic [1:0] RD_SHADOW = 2'h2;

  typedef enum logic [1:0] {ST_RESET, ST_CAPTURE, ST_RUN} acs_state_e;

endpackage

// ==== rtl/acs_shadow_bank.sv ====
`timescale 1ns/1ns
module acs_shadow_bank
  import acs_pkg::*;
#(
  parameter int DEPTH = SHADOW_DEPTH,
  parameter int IDX_W = SHADOW_IDX_W,
  parameter logic [DEPTH*8-1:0] RST = SHADOW_RESET
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic wr_en_a,
  input wire logic wr_en_b,
  input wire logic [IDX_W-1:0] wr_idx,
  input wire logic [7:0] wr_data,
  input wire logic rd_en,
  input wire logic rd_sel_b,
  input wire logic [IDX_W-1:0] rd_idx,
  input wire logic commit,
  output logic [7:0] rd_data,
  output logic [DEPTH*8-1:0] act_a,
  output logic [DEPTH*8-1:0] act_b
);

  // ----------------------------------------
  // Elaboration check
  // ----------------------------------------
  if (DEPTH < 1 || DEPTH > (1 << IDX_W)) begin : g_bad
    $error("acs_shadow_bank: DEPTH does not fit IDX_W");
  end

  // ----------------------------------------
  // Master and active copies per channel
  // ----------------------------------------
  logic [7:0] mst_a_reg [DEPTH];
  logic [7:0] mst_b_reg [DEPTH];
  logic [7:0] act_a_reg [DEPTH];
  logic [7:0] act_b_reg [DEPTH];
  logic [7:0] rd_data_reg;

  for (genvar i = 0; i < DEPTH; i++) begin : g_ent
    wire logic hit = (wr_idx == IDX_W'(i));
    always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
        mst_a_reg[i] <= RST[i*8 +: 8];
        mst_b_reg[i] <= RST[i*8 +: 8];
        act_a_reg[i] <= RST[i*8 +: 8];
        act_b_reg[i] <= RST[i*8 +: 8];
      end else begin
        if (wr_en_a && hit) begin
          mst_a_reg[i] <= wr_data;
        end
        if (wr_en_b && hit) begin
          mst_b_reg[i] <= wr_data;
        end
        if (commit) begin
          act_a_reg[i] <= mst_a_reg[i];
          act_b_reg[i] <= mst_b_reg[i];
        end
      end
    end
    assign act_a[i*8 +: 8] = act_a_reg[i];
    assign act_b[i*8 +: 8] = act_b_reg[i];
  end

  // ----------------------------------------
  // Registered readback of master copy
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rd_data_reg <= 8'h00;
    end else if (rd_en) begin
      rd_data_reg <= rd_sel_b ? mst_b_reg[rd_idx] : mst_a_reg[rd_idx];
    end
  end

  assign rd_data = rd_data_reg;

endmodule

// ==== rtl/acs_cfg_regs.sv ====
`timescale 1ns/1ns
// Summary of operation
// - Strap mode: pins are config, port ignored
// - Stabilizer strap high enables stabilizer
// - Format strap high selects twos complement
// - Output disable pin high floats outputs
// - Power-down pin high powers down
// - Reset loads register defaults
// - Shadow writes wait for commit
// - Commit copies all shadows, then clears
// - Channel select bits steer local access
// - Both bits set writes both channels
// - Both bits set reads channel A
// - Global registers ignore channel select
// - Channel select resets to both channels
// - Strap mode floats serial data pin
module acs_cfg_regs
  import acs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic serial_select_n,
  input wire logic stabilizer_strap_pin,
  input wire logic format_strap_pin,
  input wire logic output_disable_pin,
  input wire logic power_down_pin,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [ACS_ADDR_W-1:0] reg_addr,
  input wire logic [ACS_DATA_W-1:0] reg_wdata,
  output logic [ACS_DATA_W-1:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic sdio_drive_req,
  output logic sdio_oe,
  output logic strap_mode,
  output logic duty_cycle_stabilizer,
  output logic twos_comp_a,
  output logic twos_comp_b,
  output logic outputs_hiz,
  output logic power_down
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  acs_state_e state_reg;
  acs_state_e state_next;
  logic [1:0] chan_sel_reg;
  logic [1:0] rd_kind_reg;
  logic [7:0] rd_misc_reg;
  logic rvalid_reg;
  logic dcs_strap_reg;
  logic fmt_strap_reg;
  logic dcs_reg;
  logic fmt_a_reg;
  logic fmt_b_reg;
  logic hiz_reg;
  logic power_down_pin_reg;
  logic [SHADOW_DEPTH*8-1:0] act_a;
  logic [SHADOW_DEPTH*8-1:0] act_b;
  logic [7:0] bank_rdata;

  // ----------------------------------------
  // Startup sequence
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_RESET: begin
        state_next = ST_CAPTURE;
      end
      ST_CAPTURE: begin
        state_next = ST_RUN;
      end
      default: begin
        state_next = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_reg <= ST_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      dcs_strap_reg <= DCS_DEFAULT;
      fmt_strap_reg <= FMT_DEFAULT;
    end else if (state_reg == ST_CAPTURE) begin
      dcs_strap_reg <= stabilizer_strap_pin;
      fmt_strap_reg <= format_strap_pin;
    end
  end

  // ----------------------------------------
  // Access decode
  // ----------------------------------------
  // port ignored under straps
  wire logic bus_ok = (state_reg == ST_RUN) && !serial_select_n;
  wire logic wr_ok = reg_wr && bus_ok;
  wire logic rd_ok = reg_rd && bus_ok;
  wire logic hit_sel = (reg_addr == CHAN_SEL_ADDR);
  wire logic hit_commit = (reg_addr == COMMIT_ADDR);
  wire logic hit_shadow = (reg_addr >= SHADOW_FIRST) && (reg_addr <= SHADOW_LAST);
  wire logic [ACS_ADDR_W-1:0] sh_off = reg_addr - SHADOW_FIRST;
  wire logic [SHADOW_IDX_W-1:0] sh_idx = sh_off[SHADOW_IDX_W-1:0];
  wire logic is_local = hit_shadow && LOCAL_MASK[sh_idx];
  wire logic wr_a = wr_ok && hit_shadow && (!is_local || chan_sel_reg[CHAN_A_BIT]);
  wire logic wr_b = wr_ok && hit_shadow && (!is_local || chan_sel_reg[CHAN_B_BIT]);
  wire logic rd_b = is_local && !chan_sel_reg[CHAN_A_BIT] && chan_sel_reg[CHAN_B_BIT];
  wire logic commit_pulse = wr_ok && hit_commit && reg_wdata[COMMIT_BIT];
  wire logic fmt_wr_a = wr_a && (sh_idx == SHADOW_IDX_W'(FMT_IDX));
  wire logic fmt_wr_both = fmt_wr_a && wr_b;

  // ----------------------------------------
  // Channel select register
  // ----------------------------------------
  // both channels after reset
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      chan_sel_reg <= CHAN_SEL_RESET;
    end else if (wr_ok && hit_sel) begin
      chan_sel_reg <= reg_wdata[1:0];
    end
  end

  // ----------------------------------------
  // Shadow bank
  // ----------------------------------------
  // writes land in master copy
  acs_shadow_bank #(
    .DEPTH(SHADOW_DEPTH),
    .IDX_W(SHADOW_IDX_W),
    .RST(SHADOW_RESET)
  ) u_bank (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .wr_en_a(wr_a),
    .wr_en_b(wr_b),
    .wr_idx(sh_idx),
    .wr_data(reg_wdata),
    .rd_en(rd_ok && hit_shadow),
    .rd_sel_b(rd_b),
    .rd_idx(sh_idx),
    .commit(commit_pulse),
    .rd_data(bank_rdata),
    .act_a(act_a),
    .act_b(act_b)
  );

  // ----------------------------------------
  // Readback
  // ----------------------------------------
  // Commit and open addresses read zero; open bits above select too
  wire logic [1:0] rd_kind_next = hit_shadow ? RD_SHADOW : (hit_sel ? RD_CHAN_SEL : RD_ZERO);

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rvalid_reg <= 1'b0;
      rd_kind_reg <= RD_ZERO;
      rd_misc_reg <= 8'h00;
    end else begin
      rvalid_reg <= rd_ok;
      if (rd_ok) begin
        rd_kind_reg <= rd_kind_next;
        rd_misc_reg <= hit_sel ? {6'h00, chan_sel_reg} : 8'h00;
      end
    end
  end

  assign reg_rvalid = rvalid_reg;
  assign reg_rdata = (rd_kind_reg == RD_SHADOW) ? bank_rdata : rd_misc_reg;

  // ----------------------------------------
  // Configuration outputs
  // ----------------------------------------
  wire logic act_dcs = act_a[DCS_IDX*8 + DCS_BIT];
  wire logic act_fmt_a = act_a[FMT_IDX*8 + FMT_BIT];
  wire logic act_fmt_b = act_b[FMT_IDX*8 + FMT_BIT];

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      dcs_reg <= DCS_DEFAULT;
      fmt_a_reg <= FMT_DEFAULT;
      fmt_b_reg <= FMT_DEFAULT;
      hiz_reg <= HIZ_DEFAULT;
      power_down_pin_reg <= POWER_DOWN_PIN_DEFAULT;
    end else begin
      dcs_reg <= serial_select_n ? dcs_strap_reg : act_dcs;
      fmt_a_reg <= serial_select_n ? fmt_strap_reg : act_fmt_a;
      fmt_b_reg <= serial_select_n ? fmt_strap_reg : act_fmt_b;
      hiz_reg <= output_disable_pin;
      power_down_pin_reg <= power_down_pin;
    end
  end

  assign duty_cycle_stabilizer = dcs_reg;
  assign twos_comp_a = fmt_a_reg;
  assign twos_comp_b = fmt_b_reg;
  assign outputs_hiz = hiz_reg;
  assign power_down = power_down_pin_reg;
  assign strap_mode = serial_select_n;
  assign sdio_oe = sdio_drive_req && !serial_select_n;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  chk_strap_port_ignored: assert property (
    (serial_select_n && reg_wr) |=> $stable(chan_sel_reg) && !reg_rvalid)
    else $error("register write accepted in strap mode");

  chk_stab_strap_value: assert property (
    (state_reg == ST_CAPTURE) ##1 serial_select_n
      |=> duty_cycle_stabilizer == $past(stabilizer_strap_pin, 2))
    else $error("stabilizer does not follow captured strap");

  chk_fmt_strap_value: assert property (
    (state_reg == ST_CAPTURE) ##1 serial_select_n
      |=> (twos_comp_a == $past(format_strap_pin, 2)) && (twos_comp_b == twos_comp_a))
    else $error("format does not follow captured strap");

  chk_hiz_follows_pin: assert property (
    (state_reg == ST_RUN) |-> outputs_hiz == $past(output_disable_pin))
    else $error("output disable not applied");

  chk_power_down_pin_follows_pin: assert property (
    (state_reg == ST_RUN) |-> power_down == $past(power_down_pin))
    else $error("power-down not applied");

  chk_reset_chan_sel: assert property (
    $past(!rst_n) |-> (chan_sel_reg == CHAN_SEL_RESET) && duty_cycle_stabilizer)
    else $error("defaults not loaded after reset");

  chk_shadow_holds: assert property (
    (!commit_pulse && !serial_select_n) ##1 !serial_select_n
      |=> $stable(twos_comp_a) && $stable(twos_comp_b))
    else $error("shadow write changed operation without commit");

  chk_commit_loads: assert property (
    fmt_wr_a ##1 (commit_pulse && !fmt_wr_a) ##1 !serial_select_n
      |=> twos_comp_a == $past(reg_wdata[FMT_BIT], 3))
    else $error("commit did not move shadow value");

  chk_commit_reads_zero: assert property (
    (rd_ok && hit_commit) |=> reg_rvalid && (reg_rdata == 8'h00))
    else $error("commit bit did not clear");

  chk_both_written: assert property (
    fmt_wr_both ##1 (commit_pulse && !fmt_wr_a && !wr_b) ##1 !serial_select_n
      |=> twos_comp_a == twos_comp_b)
    else $error("dual-channel write missed a channel");

  chk_sdio_floats: assert property (
    serial_select_n |-> !sdio_oe)
    else $error("serial data driven in strap mode");

  cov_commit_seen: cover property (fmt_wr_a ##1 commit_pulse);
  cov_both_write: cover property (fmt_wr_both);
  cov_read_b: cover property (rd_ok && rd_b);
  cov_strap_run: cover property ((state_reg == ST_RUN) && serial_select_n);

endmodule

// ==== bench/acs_host_model.sv ====
`timescale 1ns/1ns
module acs_host_model
  import acs_pkg::*;
(
  input wire logic clk_sys,
  output logic reg_wr,
  output logic reg_rd,
  output logic [ACS_ADDR_W-1:0] reg_addr,
  output logic [ACS_DATA_W-1:0] reg_wdata,
  input wire logic [ACS_DATA_W-1:0] reg_rdata,
  input wire logic reg_rvalid
);
  // ----------------------------------------
  // Host framer side of the register port
  // ----------------------------------------
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
  end

  // Released bus shows inverted values, never a stale copy
  task automatic release_bus();
    @(negedge clk_sys);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = ~reg_addr;
    reg_wdata = ~reg_wdata;
  endtask

  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    release_bus();
  endtask

  // Two writes back to back, strobe held up between them
  task automatic wr2(input logic [12:0] a0, input logic [7:0] d0,
    input logic [12:0] a1, input logic [7:0] d1);
    @(negedge clk_sys);
    reg_addr = a0;
    reg_wdata = d0;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_addr = a1;
    reg_wdata = d1;
    release_bus();
  endtask

  // Bounded wait, so a refused read returns got low
  task automatic rd(input logic [12:0] a, output logic [7:0] d, output logic got);
    int n;
    @(negedge clk_sys);
    reg_addr = a;
    reg_rd = 1'b1;
    release_bus();
    got = 1'b0;
    d = 8'h00;
    for (n = 0; n < 4 && !got; n++) begin
      if (reg_rvalid === 1'b1) begin
        got = 1'b1;
        d = reg_rdata;
      end else begin
        @(negedge clk_sys);
      end
    end
  endtask
endmodule

// ==== bench/acs_cfg_regs_test.sv ====
`timescale 1ns/1ns
module acs_cfg_regs_test
  import acs_pkg::*;
;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  logic clk_sys, rst_n, serial_select_n, stabilizer_strap_pin, format_strap_pin;
  logic output_disable_pin, power_down_pin, reg_wr, reg_rd, reg_rvalid, sdio_drive_req;
  logic sdio_oe, strap_mode, duty_cycle_stabilizer, twos_comp_a, twos_comp_b;
  logic outputs_hiz, power_down;
  logic [ACS_ADDR_W-1:0] reg_addr;
  logic [ACS_DATA_W-1:0] reg_wdata, reg_rdata, rd_byte;
  logic rd_got;
  int failures = 0;
  int n_compared = 0;

  acs_cfg_regs dut (.clk_sys(clk_sys), .rst_n(rst_n), .serial_select_n(serial_select_n),
    .stabilizer_strap_pin(stabilizer_strap_pin), .format_strap_pin(format_strap_pin),
    .output_disable_pin(output_disable_pin), .power_down_pin(power_down_pin),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .sdio_drive_req(sdio_drive_req),
    .sdio_oe(sdio_oe), .strap_mode(strap_mode), .duty_cycle_stabilizer(duty_cycle_stabilizer),
    .twos_comp_a(twos_comp_a), .twos_comp_b(twos_comp_b), .outputs_hiz(outputs_hiz),
    .power_down(power_down));

  acs_host_model host (.clk_sys(clk_sys), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid));

  // ----------------------------------------
  // Compare and access tasks
  // ----------------------------------------
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic rchk(input logic [12:0] a, input logic [7:0] exp);
    host.rd(a, rd_byte, rd_got);
    chk1(rd_got, 1'b1);
    chk8(rd_byte, exp);
  endtask

  // Startup needs two edges before the first strobe, three before the strap outputs settle
  task automatic restart();
    rst_n = 1'b0;
    repeat (20) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (3) @(negedge clk_sys);
  endtask

  task automatic summarize();
    if (failures == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Clock, watchdog and tests
  // ----------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  initial begin
    #50000;
    failures++;
    summarize();
  end

  initial begin
    serial_select_n = 1'b0;
    stabilizer_strap_pin = 1'b1;
    format_strap_pin = 1'b0;
    output_disable_pin = 1'b0;
    power_down_pin = 1'b0;
    sdio_drive_req = 1'b0;
    restart();
    chk1(duty_cycle_stabilizer, 1'b1);
    chk1(twos_comp_a, 1'b0);
    rchk(CHAN_SEL_ADDR, 8'h03);
    rchk(13'h009, 8'h01);
    host.wr(13'h014, 8'h01);
    repeat (3) @(negedge clk_sys);
    chk1(twos_comp_a, 1'b0);
    rchk(13'h014, 8'h01);
    host.wr(COMMIT_ADDR, 8'h01);
    repeat (2) @(negedge clk_sys);
    chk1(twos_comp_a, 1'b1);
    chk1(twos_comp_b, 1'b1);
    rchk(COMMIT_ADDR, 8'h00);
    host.wr(CHAN_SEL_ADDR, 8'h02);
    host.wr(13'h014, 8'h00);
    host.wr(13'h009, 8'h00);
    host.wr(COMMIT_ADDR, 8'h01);
    repeat (2) @(negedge clk_sys);
    chk1(twos_comp_a, 1'b1);
    chk1(twos_comp_b, 1'b0);
    chk1(duty_cycle_stabilizer, 1'b0);
    rchk(13'h014, 8'h00);
    host.wr(CHAN_SEL_ADDR, 8'h01);
    rchk(13'h014, 8'h01);
    rchk(13'h009, 8'h00);
    host.wr(CHAN_SEL_ADDR, 8'h03);
    rchk(13'h014, 8'h01);
    host.wr2(13'h014, 8'h01, COMMIT_ADDR, 8'h01);
    repeat (2) @(negedge clk_sys);
    chk1(twos_comp_a, 1'b1);
    chk1(twos_comp_b, 1'b1);
    rchk(13'h013, 8'h00);
    output_disable_pin = 1'b1;
    power_down_pin = 1'b1;
    sdio_drive_req = 1'b1;
    @(negedge clk_sys);
    chk1(outputs_hiz, 1'b1);
    chk1(power_down, 1'b1);
    chk1(sdio_oe, 1'b1);
    output_disable_pin = 1'b0;
    power_down_pin = 1'b0;
    @(negedge clk_sys);
    chk1(outputs_hiz, 1'b0);
    chk1(power_down, 1'b0);
    // board ties select high for straps
    serial_select_n = 1'b1;
    stabilizer_strap_pin = 1'b0;
    format_strap_pin = 1'b1;
    restart();
    chk1(strap_mode, 1'b1);
    chk1(duty_cycle_stabilizer, 1'b0);
    chk1(twos_comp_a, 1'b1);
    chk1(twos_comp_b, 1'b1);
    chk1(sdio_oe, 1'b0);
    stabilizer_strap_pin = 1'b1;
    format_strap_pin = 1'b0;
    host.wr(13'h014, 8'h00);
    host.wr(COMMIT_ADDR, 8'h01);
    repeat (3) @(negedge clk_sys);
    chk1(duty_cycle_stabilizer, 1'b0);
    chk1(twos_comp_a, 1'b1);
    host.rd(CHAN_SEL_ADDR, rd_byte, rd_got);
    chk1(rd_got, 1'b0);
    summarize();
  end
endmodule
